// ===== src/smfd_fault_detect.sv
// Fault detection, current error list and error history for the speed monitor
`timescale 1ns/100ps
`default_nettype none
module smfd_fault_detect #(
  parameter int unsigned STUCK_CYCLES = smfd_pkg::STUCK_CYC,
  parameter int unsigned WIN_CYCLES = smfd_pkg::WIN_CYC
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic histRst,
  // Sensor and panel pins
  input wire smfd_pkg::smfd_tracks_s tracks,
  input wire smfd_pkg::smfd_select_s paramSel,
  input wire logic start_input,
  input wire logic terminatorOk,
  // Configuration and analog judgement
  input wire smfd_pkg::smfd_cfg_s cfg,
  input wire logic [2:0] offsetSeen,
  // History read port
  input wire logic [4:0] histRdIdx,
  output smfd_pkg::smfd_hist_s histRdData,
  // Current errors
  output logic faultInd,
  output logic [3:0] curCount,
  output logic [7:0][15:0] curCodes
);

  localparam int unsigned NSYNC = 10;

  function automatic logic [15:0] errCode(input int unsigned idx);
    case (idx)
      smfd_pkg::IDX_SELECT: errCode = smfd_pkg::CODE_SELECT;
      smfd_pkg::IDX_FREQDEV: errCode = smfd_pkg::CODE_FREQDEV;
      smfd_pkg::IDX_POSPROX: errCode = smfd_pkg::CODE_POSPROX;
      smfd_pkg::IDX_TERM: errCode = smfd_pkg::CODE_TERM;
      smfd_pkg::IDX_HIGH_A: errCode = smfd_pkg::CODE_HIGH_A;
      smfd_pkg::IDX_LOW_A: errCode = smfd_pkg::CODE_LOW_A;
      smfd_pkg::IDX_HIGH_B: errCode = smfd_pkg::CODE_HIGH_B;
      smfd_pkg::IDX_LOW_B: errCode = smfd_pkg::CODE_LOW_B;
      smfd_pkg::IDX_OFS_A: errCode = smfd_pkg::CODE_OFS_A;
      smfd_pkg::IDX_OFS_AN: errCode = smfd_pkg::CODE_OFS_AN;
      default: errCode = smfd_pkg::CODE_OFS_B;
    endcase
  endfunction

  // Two-stage synchronisers for pin inputs
  // Warm-up flag hides the cleared synchroniser until real pin levels arrive
  logic [NSYNC-1:0] syncIn, sync1_reg, sync2_reg;
  logic [1:0] warm_reg;
  assign syncIn = {tracks, paramSel, start_input, terminatorOk};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      warm_reg <= 2'h0;
    end else begin
      sync1_reg <= syncIn;
      sync2_reg <= sync1_reg;
      warm_reg <= {warm_reg[0], 1'b1};
    end
  end

  smfd_pkg::smfd_tracks_s trk;
  smfd_pkg::smfd_select_s sel;
  logic startS, termS;
  assign trk = sync2_reg[9:6];
  assign sel = sync2_reg[5:2];
  assign startS = sync2_reg[1];
  assign termS = sync2_reg[0];

  // Stuck-level watch on both encoder pairs
  logic highA, lowA, highB, lowB;
  smfd_pair_watch #(.STUCK_CYCLES(STUCK_CYCLES)) watchA (
    .core_clk(core_clk),
    .rst(rst),
    .enable(~cfg.sensorIsProx),
    .trackPos(trk.a),
    .trackNeg(trk.aN),
    .stuckHigh(highA),
    .stuckLow(lowA)
  );
  smfd_pair_watch #(.STUCK_CYCLES(STUCK_CYCLES)) watchB (
    .core_clk(core_clk),
    .rst(rst),
    .enable(~cfg.sensorIsProx),
    .trackPos(trk.b),
    .trackNeg(trk.bN),
    .stuckHigh(highB),
    .stuckLow(lowB)
  );

  // Frequency comparison of tracks A and B over a window
  logic [31:0] win_reg, win_next;
  logic [15:0] cntA_reg, cntA_next, cntB_reg, cntB_next;
  logic prevA_reg, prevB_reg, prevStart_reg;
  logic devSet, devClr;
  logic [15:0] diff;
  always_comb begin
    win_next = win_reg + 32'h00000001;
    cntA_next = cntA_reg;
    cntB_next = cntB_reg;
    devSet = 1'b0;
    devClr = 1'b0;
    diff = (cntA_reg > cntB_reg) ? cntA_reg - cntB_reg : cntB_reg - cntA_reg;
    if (trk.a && !prevA_reg && cntA_reg != 16'hffff) begin
      cntA_next = cntA_reg + 16'h0001;
    end
    if (trk.b && !prevB_reg && cntB_reg != 16'hffff) begin
      cntB_next = cntB_reg + 16'h0001;
    end
    if (win_reg >= WIN_CYCLES - 32'h00000001) begin
      win_next = 32'h00000000;
      cntA_next = 16'h0000;
      cntB_next = 16'h0000;
      if (cfg.sensorIsProx && diff > smfd_pkg::FREQ_TOL) begin
        devSet = 1'b1;
      end else if (cntA_reg > smfd_pkg::STANDSTILL_EDGES &&
                   cntB_reg > smfd_pkg::STANDSTILL_EDGES) begin
        devClr = 1'b1;
      end
    end
    if (prevStart_reg && !startS) begin
      devClr = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      win_reg <= 32'h00000000;
      cntA_reg <= 16'h0000;
      cntB_reg <= 16'h0000;
      prevA_reg <= 1'b0;
      prevB_reg <= 1'b0;
      prevStart_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      cntA_reg <= cntA_next;
      cntB_reg <= cntB_next;
      prevA_reg <= trk.a;
      prevB_reg <= trk.b;
      prevStart_reg <= startS;
    end
  end

  // Raw error conditions
  logic [smfd_pkg::ERR_NUM-1:0] raw;
  always_comb begin
    raw = '0;
    raw[smfd_pkg::IDX_SELECT] = warm_reg[1] && cfg.oneOfFourMode && !$onehot(sel);
    raw[smfd_pkg::IDX_FREQDEV] = devSet;
    raw[smfd_pkg::IDX_POSPROX] = cfg.sensorIsProx && (cfg.posMonEn || cfg.dirMonEn);
    raw[smfd_pkg::IDX_TERM] = warm_reg[1] && !termS;
    raw[smfd_pkg::IDX_HIGH_A] = highA;
    raw[smfd_pkg::IDX_HIGH_B] = highB;
    raw[smfd_pkg::IDX_LOW_A] = lowA;
    raw[smfd_pkg::IDX_LOW_B] = lowB;
    raw[smfd_pkg::IDX_OFS_A] = offsetSeen[0];
    raw[smfd_pkg::IDX_OFS_AN] = offsetSeen[1];
    raw[smfd_pkg::IDX_OFS_B] = offsetSeen[2];
  end

  // Latched errors, pending log entries and current list
  logic [smfd_pkg::ERR_NUM-1:0] latched_reg, latched_next, pend_reg, pend_next, ack;
  logic [7:0][15:0] codes_next, codes_reg;
  logic [3:0] count_next, count_reg;
  logic fault_reg, fault_next;
  logic logEn;
  logic [15:0] logCode;
  always_comb begin
    // held until reset, except FREQDEV, which devClr clears; set wins over clear
    latched_next = latched_reg | raw;
    if (devClr && !raw[smfd_pkg::IDX_FREQDEV]) begin
      latched_next[smfd_pkg::IDX_FREQDEV] = 1'b0;
    end
    // log each new error once, lowest index first
    ack = '0;
    logEn = 1'b0;
    logCode = 16'h0000;
    for (int i = smfd_pkg::ERR_NUM - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        ack = '0;
        ack[i] = 1'b1;
        logEn = 1'b1;
        logCode = errCode(i);
      end
    end
    pend_next = (pend_reg & ~ack) | (raw & ~latched_reg);
    codes_next = '0;
    count_next = 4'h0;
    for (int i = 0; i < smfd_pkg::ERR_NUM; i++) begin
      if (latched_reg[i] && count_next < smfd_pkg::CUR_SLOTS[3:0]) begin
        codes_next[count_next[2:0]] = errCode(i);
        count_next = count_next + 4'h1;
      end
    end
    fault_next = |latched_reg;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latched_reg <= '0;
      pend_reg <= '0;
      codes_reg <= '0;
      count_reg <= 4'h0;
      fault_reg <= 1'b0;
    end else begin
      latched_reg <= latched_next;
      pend_reg <= pend_next;
      codes_reg <= codes_next;
      count_reg <= count_next;
      fault_reg <= fault_next;
    end
  end

  // Error history, kept across unit reset
  logic [15:0] hist [smfd_pkg::HIST_DEPTH];
  logic [4:0] wrPtr_reg, wrPtr_next, used_reg, used_next;
  logic [5:0] rdSum;
  logic [4:0] rdPtr;
  smfd_pkg::smfd_hist_s rd_next, rd_reg;
  always_comb begin
    wrPtr_next = wrPtr_reg;
    used_next = used_reg;
    if (logEn) begin
      wrPtr_next = (wrPtr_reg == smfd_pkg::HIST_DEPTH[4:0] - 5'h01) ? 5'h00 :
                   wrPtr_reg + 5'h01;
      if (used_reg != smfd_pkg::HIST_DEPTH[4:0]) begin
        used_next = used_reg + 5'h01;
      end
    end
    rdSum = {1'b0, wrPtr_reg} + smfd_pkg::HIST_DEPTH[5:0] - 6'h01 - {1'b0, histRdIdx};
    rdPtr = (rdSum >= smfd_pkg::HIST_DEPTH[5:0]) ?
            5'(rdSum - smfd_pkg::HIST_DEPTH[5:0]) : rdSum[4:0];
    rd_next.valid = histRdIdx < used_reg;
    rd_next.seqNo = histRdIdx + 5'h01;
    rd_next.code = (histRdIdx < used_reg) ? hist[rdPtr] : 16'h0000;
  end

  always_ff @(posedge core_clk) begin
    if (logEn) begin
      hist[wrPtr_reg] <= logCode;
    end
  end

  always_ff @(posedge core_clk or posedge histRst) begin
    if (histRst) begin
      wrPtr_reg <= 5'h00;
      used_reg <= 5'h00;
      rd_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      used_reg <= used_next;
      rd_reg <= rd_next;
    end
  end

  assign histRdData = rd_reg;
  assign faultInd = fault_reg;
  assign curCount = count_reg;
  assign curCodes = codes_reg;

endmodule
`default_nettype wire

// ===== pkg/smfd_pkg.sv
// Package with constants and carrier types for the speed monitor fault detector
package smfd_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 250;

  // Timing figures in their own units
  localparam int unsigned STUCK_TIME_US = 1000;
  localparam int unsigned WIN_TIME_US = 100000;

  // Timing counts in clock cycles
  localparam int unsigned STUCK_CYC = STUCK_TIME_US * CLK_MHZ;
  localparam int unsigned WIN_CYC = WIN_TIME_US * CLK_MHZ;

  // Frequency comparison limits, in edges per window
  localparam logic [15:0] FREQ_TOL = 16'h0004;
  localparam logic [15:0] STANDSTILL_EDGES = 16'h0002;

  // Error sources and their index in the error vector
  localparam int unsigned ERR_NUM = 11;
  localparam int unsigned IDX_SELECT = 0;
  localparam int unsigned IDX_FREQDEV = 1;
  localparam int unsigned IDX_POSPROX = 2;
  localparam int unsigned IDX_TERM = 3;
  localparam int unsigned IDX_HIGH_A = 4;
  localparam int unsigned IDX_LOW_A = 5;
  localparam int unsigned IDX_HIGH_B = 6;
  localparam int unsigned IDX_LOW_B = 7;
  localparam int unsigned IDX_OFS_A = 8;
  localparam int unsigned IDX_OFS_AN = 9;
  localparam int unsigned IDX_OFS_B = 10;

  // Error codes
  localparam logic [15:0] CODE_SELECT = 16'h1b58;
  localparam logic [15:0] CODE_FREQDEV = 16'h1770;
  localparam logic [15:0] CODE_POSPROX = 16'h138b;
  localparam logic [15:0] CODE_TERM = 16'h0fac;
  localparam logic [15:0] CODE_HIGH_A = 16'h2801;
  localparam logic [15:0] CODE_LOW_A = 16'h2802;
  localparam logic [15:0] CODE_HIGH_B = 16'h2803;
  localparam logic [15:0] CODE_LOW_B = 16'h2804;
  localparam logic [15:0] CODE_OFS_A = 16'h2805;
  localparam logic [15:0] CODE_OFS_AN = 16'h2806;
  localparam logic [15:0] CODE_OFS_B = 16'h2807;

  // Depths of history and current list
  localparam int unsigned HIST_DEPTH = 20;
  localparam int unsigned CUR_SLOTS = 8;

  // Sensor tracks as seen at the pins
  typedef struct packed {
    logic a;
    logic aN;
    logic b;
    logic bN;
  } smfd_tracks_s;

  // Parameter-set select inputs
  typedef struct packed {
    logic paramSetEighth;
    logic paramSetFourth;
    logic paramSetSecond;
    logic paramSetFirst;
  } smfd_select_s;

  // Configuration levels
  typedef struct packed {
    logic oneOfFourMode;
    logic sensorIsProx;
    logic posMonEn;
    logic dirMonEn;
  } smfd_cfg_s;

  // One history read answer
  typedef struct packed {
    logic valid;
    logic [4:0] seqNo;
    logic [15:0] code;
  } smfd_hist_s;

endpackage

// ===== src/smfd_pair_watch.sv
// Stuck-level watch for one complementary track pair
`timescale 1ns/100ps
`default_nettype none
module smfd_pair_watch #(
  parameter int unsigned STUCK_CYCLES = smfd_pkg::STUCK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Enable level and track pair, the pair already synchronised
  input wire logic enable,
  input wire logic trackPos,
  input wire logic trackNeg,
  // Stuck levels
  output logic stuckHigh,
  output logic stuckLow
);

  logic [23:0] cnt_reg, cnt_next;
  logic high_reg, high_next, low_reg, low_next;

  // Both lines at one level count toward a stuck fault
  always_comb begin
    cnt_next = 24'h000000;
    high_next = high_reg;
    low_next = low_reg;
    if (enable && (trackPos == trackNeg)) begin
      if (cnt_reg >= STUCK_CYCLES[23:0] - 24'h000001) begin
        cnt_next = cnt_reg;
        high_next = trackPos;
        low_next = ~trackPos;
      end else begin
        cnt_next = cnt_reg + 24'h000001;
      end
    end else begin
      high_next = 1'b0;
      low_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 24'h000000;
      high_reg <= 1'b0;
      low_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      high_reg <= high_next;
      low_reg <= low_next;
    end
  end

  assign stuckHigh = high_reg;
  assign stuckLow = low_reg;

endmodule
`default_nettype wire

// ===== verif/smfd_fault_detect_sva.sv
// Port checker for the fault detector
`timescale 1ns/100ps
`default_nettype none
module smfd_fault_detect_sva #(
  parameter int unsigned STUCK_CYCLES = smfd_pkg::STUCK_CYC,
  parameter int unsigned WIN_CYCLES = smfd_pkg::WIN_CYC
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic histRst,
  // Pins and configuration
  input wire smfd_pkg::smfd_tracks_s tracks,
  input wire smfd_pkg::smfd_select_s paramSel,
  input wire logic start_input,
  input wire logic terminatorOk,
  input wire smfd_pkg::smfd_cfg_s cfg,
  input wire logic [2:0] offsetSeen,
  // History and current errors
  input wire logic [4:0] histRdIdx,
  input wire smfd_pkg::smfd_hist_s histRdData,
  input wire logic faultInd,
  input wire logic [3:0] curCount,
  input wire logic [7:0][15:0] curCodes
);
  logic [31:0] hiCnt_reg;
  logic [31:0] hiCnt_next;
  logic ofsShown;
  logic tailZero;
  always_comb begin
    hiCnt_next = (tracks.a && tracks.aN && !cfg.sensorIsProx) ? hiCnt_reg + 32'h1 : 32'h0;
    ofsShown = 1'b0;
    tailZero = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (curCodes[i] == smfd_pkg::CODE_OFS_A) ofsShown = 1'b1;
      if (i >= int'(curCount) && curCodes[i] != 16'h0000) tailZero = 1'b0;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hiCnt_reg <= 32'h0;
    end else begin
      hiCnt_reg <= hiCnt_next;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_badSel;
    (cfg.oneOfFourMode && $countones(paramSel) != 1)[*5];
  endsequence
  sequence s_posProx;
    (cfg.sensorIsProx && (cfg.posMonEn || cfg.dirMonEn))[*4];
  endsequence
  sequence s_termLost;
    (!terminatorOk)[*5];
  endsequence
  sequence s_ofsA;
    offsetSeen[0][*4] ##0 curCount < 4'h8;
  endsequence
  AST_SELECT: assert property (s_badSel |-> faultInd)
    else $error("bad select not flagged");
  AST_POSPROX: assert property (s_posProx |-> faultInd)
    else $error("monitoring with proximity switch not flagged");
  AST_TERM: assert property (s_termLost |-> faultInd)
    else $error("open terminator not flagged");
  AST_STUCK: assert property (hiCnt_reg == STUCK_CYCLES + 8 |-> faultInd)
    else $error("stuck track not flagged");
  AST_OFS: assert property (s_ofsA |-> ofsShown)
    else $error("offset code missing from list");
  AST_FAULT: assert property (faultInd == (curCount != 4'h0))
    else $error("fault flag disagrees with count");
  AST_LIST: assert property (curCount <= 4'h8 && tailZero)
    else $error("current list malformed");
  AST_HOLD: assert property (faultInd && curCodes[0] != smfd_pkg::CODE_FREQDEV
    && curCodes[1] != smfd_pkg::CODE_FREQDEV |=> faultInd) else $error("fault dropped");
  AST_HSEQ: assert property (histRdData.valid |-> histRdData.seqNo == $past(histRdIdx) + 5'h1)
    else $error("history sequence number wrong");
  AST_HNONE: assert property (!histRdData.valid |-> histRdData.code == 16'h0000)
    else $error("empty history entry has a code");
endmodule
bind smfd_fault_detect smfd_fault_detect_sva #(.STUCK_CYCLES(STUCK_CYCLES),
  .WIN_CYCLES(WIN_CYCLES)) u_sva (.core_clk(core_clk), .rst(rst), .histRst(histRst),
  .tracks(tracks), .paramSel(paramSel), .start_input(start_input),
  .terminatorOk(terminatorOk), .cfg(cfg), .offsetSeen(offsetSeen), .histRdIdx(histRdIdx),
  .histRdData(histRdData), .faultInd(faultInd), .curCount(curCount), .curCodes(curCodes));
`default_nettype wire

// ===== verif/smfd_sensor_model.sv
// Behavioural encoder or proximity switch pair on tracks A and B
`timescale 1ns/100ps
`default_nettype none
module smfd_sensor_model (
  // Motion: 0 stopped, 1 running, 2 stuck
  input wire logic [1:0] mode,
  input wire logic stuckA,
  input wire logic stuckB,
  // Half periods in ns
  input wire integer halfA,
  input wire integer halfB,
  // Sensor pins
  output wire smfd_pkg::smfd_tracks_s tracks
);
  logic a = 1'b0;
  logic b = 1'b0;
  always begin
    #(halfA > 0 ? halfA : 1);
    if (mode == 2'h1) a = ~a;
  end
  always begin
    #(halfB > 0 ? halfB : 1);
    if (mode == 2'h1) b = ~b;
  end
  assign tracks = (mode == 2'h2) ? {stuckA, stuckA, stuckB, stuckB} : {a, ~a, b, ~b};
endmodule
`default_nettype wire

// ===== verif/smfd_fault_detect_tb.sv
// Self-checking bench for the fault detector
`timescale 1ns/100ps
`default_nettype none
module smfd_fault_detect_tb;
  localparam int unsigned ST = 16;
  localparam int unsigned WN = 64;
  localparam logic [10:0][15:0] CODES = {smfd_pkg::CODE_OFS_B, smfd_pkg::CODE_OFS_AN,
    smfd_pkg::CODE_OFS_A, smfd_pkg::CODE_LOW_B, smfd_pkg::CODE_HIGH_B, smfd_pkg::CODE_LOW_A,
    smfd_pkg::CODE_HIGH_A, smfd_pkg::CODE_TERM, smfd_pkg::CODE_POSPROX,
    smfd_pkg::CODE_FREQDEV, smfd_pkg::CODE_SELECT};
  logic core_clk, rst, histRst, start_input, terminatorOk, faultInd, stuckA, stuckB;
  smfd_pkg::smfd_select_s paramSel;
  smfd_pkg::smfd_cfg_s cfg;
  smfd_pkg::smfd_tracks_s tracks;
  smfd_pkg::smfd_hist_s histRdData;
  logic [2:0] offsetSeen;
  logic [4:0] histRdIdx;
  logic [3:0] curCount, v;
  logic [7:0][15:0] curCodes;
  logic [1:0] mode;
  int halfA, halfB, n_mismatch, comparisons;
  smfd_sensor_model sensor (.mode(mode), .stuckA(stuckA), .stuckB(stuckB), .halfA(halfA),
    .halfB(halfB), .tracks(tracks));
  smfd_fault_detect #(.STUCK_CYCLES(ST), .WIN_CYCLES(WN)) uut (.core_clk(core_clk),
    .rst(rst), .histRst(histRst), .tracks(tracks), .paramSel(paramSel),
    .start_input(start_input), .terminatorOk(terminatorOk), .cfg(cfg),
    .offsetSeen(offsetSeen), .histRdIdx(histRdIdx), .histRdData(histRdData),
    .faultInd(faultInd), .curCount(curCount), .curCodes(curCodes));
  function automatic logic [131:0] expList(input logic [10:0] errs);
    logic [3:0] n;
    logic [7:0][15:0] c;
    n = 4'h0;
    c = '0;
    for (int i = 0; i < 11; i++) begin
      if (errs[i] && n < 4'h8) begin
        c[n[2:0]] = CODES[i];
        n++;
      end
    end
    return {n, c};
  endfunction
  task automatic check(input logic [132:0] got, input logic [132:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic list(input logic [10:0] errs);
    check({faultInd, curCount, curCodes}, {|errs, expList(errs)});
  endtask
  task automatic hist(input logic [4:0] idx, input logic [15:0] code, input logic ok);
    histRdIdx = idx;
    wait_n(2);
    check({histRdData.valid, histRdData.code}, {ok, code});
    if (ok) check(histRdData.seqNo, idx + 5'h1);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    wait_n(20);
    rst = 1'b0;
    histRst = 1'b0;
    wait_n(2);
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    histRst = 1'b1;
    start_input = 1'b0;
    terminatorOk = 1'b1;
    paramSel = 4'h1;
    cfg = 4'h8;
    offsetSeen = 3'h0;
    histRdIdx = 5'h00;
    mode = 2'h1;
    stuckA = 1'b0;
    stuckB = 1'b0;
    halfA = 10;
    halfB = 10;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(86));
    do_reset();
    hist(5'h00, 16'h0000, 1'b0);
    repeat (20) begin
      paramSel = 4'h1 << ($urandom % 4);
      wait_n(7);
      list(11'h000);
    end
    do v = 4'($urandom % 16); while ($countones(v) == 1);
    paramSel = v;
    wait_n(8);
    list(11'h001);
    hist(5'h00, smfd_pkg::CODE_SELECT, 1'b1);
    hist(5'h01, 16'h0000, 1'b0);
    paramSel = 4'h2;
    do_reset();
    list(11'h000);
    hist(5'h00, smfd_pkg::CODE_SELECT, 1'b1);
    terminatorOk = 1'b0;
    wait_n(8);
    offsetSeen = 3'h7;
    wait_n(8);
    list(11'h708);
    hist(5'h00, smfd_pkg::CODE_OFS_B, 1'b1);
    hist(5'h02, smfd_pkg::CODE_OFS_A, 1'b1);
    hist(5'h03, smfd_pkg::CODE_TERM, 1'b1);
    hist(5'h04, smfd_pkg::CODE_SELECT, 1'b1);
    terminatorOk = 1'b1;
    offsetSeen = 3'h0;
    do_reset();
    cfg = 4'h4;
    halfA = 8;
    halfB = 64;
    wait_n(3 * WN);
    list(11'h002);
    halfB = 8;
    wait_n(3 * WN);
    list(11'h000);
    halfB = 64;
    wait_n(3 * WN);
    mode = 2'h0;
    start_input = 1'b1;
    wait_n(2 * WN);
    list(11'h002);
    start_input = 1'b0;
    wait_n(8);
    list(11'h000);
    mode = 2'h1;
    cfg = 4'he;
    paramSel = 4'h3;
    terminatorOk = 1'b0;
    offsetSeen = 3'h7;
    wait_n(3 * WN);
    list(11'h70f);
    cfg = 4'h8;
    mode = 2'h2;
    stuckA = 1'b1;
    wait_n(ST + 16);
    list(11'h79f);
    paramSel = 4'h4;
    terminatorOk = 1'b1;
    offsetSeen = 3'h0;
    stuckA = 1'b0;
    stuckB = 1'b1;
    do_reset();
    wait_n(ST + 16);
    list(11'h060);
    hist(5'h00, smfd_pkg::CODE_HIGH_B, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
